// >>> src/tp_proc_pkg.sv
// Package: constants, register map and types for the trackpad channel processor.
// Assumes a single pclk domain and an APB slave with 32-bit data.
package tp_proc_pkg;
  localparam int unsigned clk_hz = 125_000_000;
  localparam int unsigned ref_interval_max_s = 60;
  localparam int unsigned sec_ticks = clk_hz;
  localparam logic [7:0] damp_scale = 8'h08;
  localparam logic [7:0] damp_sub = 8'h07;
  localparam int unsigned damp_shift = 11;
  localparam int unsigned thr_shift = 7;
  localparam logic [11:0] off_ctrl = 12'h000;
  localparam logic [11:0] off_alp_cfg = 12'h004;
  localparam logic [11:0] off_thr = 12'h008;
  localparam logic [11:0] off_max = 12'h00c;
  localparam logic [11:0] off_beta = 12'h010;
  localparam logic [11:0] off_status = 12'h014;
  localparam logic [11:0] off_alp_cnt = 12'h018;
  localparam logic [11:0] off_alp_lta = 12'h01c;
  localparam logic [11:0] off_sel = 12'h020;
  localparam logic [11:0] off_ch = 12'h024;
  localparam logic [11:0] off_touch = 12'h028;
  localparam logic [15:0] max_count_rst = 16'hffff;
  localparam logic [7:0] beta_rst = 8'h08;
  localparam logic [5:0] ref_interval_rst = 6'h0a;
  localparam logic [7:0] sleep_cycles_rst = 8'h00;
  typedef enum logic [1:0] {mode_active, mode_idle, mode_lp1, mode_lp2} power_mode_t;
  // Damping step toward a target: filt + (target - filt) * (8*beta - 7) / 2048
  function automatic logic [17:0] damp_step(input logic [17:0] filt, input logic [17:0] target,
                                            input logic [7:0] beta);
    logic signed [19:0] diff;
    logic signed [31:0] prod;
    logic [11:0] fac;
    diff = $signed({2'b00, target}) - $signed({2'b00, filt});
    fac = (12'({4'h0, beta}) * 12'({4'h0, damp_scale})) - 12'({4'h0, damp_sub});
    prod = 32'(diff) * $signed({20'h0_0000, fac});
    damp_step = 18'($signed({14'h0000, filt}) + (prod >>> damp_shift));
  endfunction
  function automatic logic [23:0] ref_thr(input logic [15:0] refv, input logic [7:0] mult);
    ref_thr = 24'({8'h00, refv}) + ((24'({8'h00, refv}) * 24'({16'h0000, mult})) >> thr_shift);
  endfunction
endpackage

// >>> src/alp_debounce_if.sv
// Interface: raw/debounced detect between alternate channel core and debouncer.
`timescale 1ns/1ps
interface alp_debounce_if;
  logic raw;
  logic [7:0] set_cnt;
  logic [7:0] clr_cnt;
  logic flag;
  modport core (output raw, output set_cnt, output clr_cnt, input flag);
  modport filt (input raw, input set_cnt, input clr_cnt, output flag);
endinterface

// >>> src/alp_debounce.sv
// Debouncer for the alternate channel detect output.
// Assumes raw is updated once per alternate-channel sample strobe.
`timescale 1ns/1ps
module alp_debounce
  import tp_proc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample,
  alp_debounce_if.filt db
);
  typedef struct packed {
    logic flag;
    logic [7:0] cnt;
  } db_state_t;
  db_state_t st_reg, st_next;

  always_comb
  begin
    st_next = st_reg;
    if (sample)
    begin
      if (db.raw != st_reg.flag)
      begin
        if (st_reg.cnt >= (st_reg.flag ? db.clr_cnt : db.set_cnt))
        begin
          st_next.flag = db.raw;
          st_next.cnt = 8'h00;
        end
        else
          st_next.cnt = st_reg.cnt + 8'h01;
      end
      else
        st_next.cnt = 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  assign db.flag = st_reg.flag;

  chk_flag_on_sample: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(sample) |-> $stable(st_reg.flag)) else $error("debounce flag moved without sample");
endmodule

// >>> src/tp_proc.sv
// Trackpad channel processor: counts, deltas, references, touch and alternate channel.
// Assumes a front end that strobes one count per cycle with row and column; APB at pclk.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module tp_proc
  import tp_proc_pkg::*;
#(
  parameter int unsigned ch_max = 64,
  parameter int unsigned ch_w = 6,
  parameter int unsigned sec_cycles = sec_ticks
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] power_mode,
  input wire logic core_asleep,
  input wire logic tp_valid,
  input wire logic [3:0] tp_row,
  input wire logic [3:0] tp_col,
  input wire logic [15:0] tp_raw,
  input wire logic alp_valid,
  input wire logic [15:0] engine_a_raw,
  input wire logic [15:0] engine_b_raw,
  output logic alternate_detect_flag,
  output logic any_touch,
  output logic alp_sensing_active,
  output logic sleep_cycle_wake
);
  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic manual;
    logic count_filter_en;
    logic sense_self;
    logic [3:0] receive_column_total;
    logic [3:0] transmit_row_total;
    logic [7:0] rx_en;
    logic [7:0] tx_en;
    logic [7:0] sleep_sensing_cycle_count;
    logic [7:0] set_mult;
    logic [7:0] clr_mult;
    logic [15:0] alternate_delta_limit;
    logic [7:0] assert_cnt;
    logic [7:0] release_cnt;
    logic [15:0] max_count;
    logic [7:0] alternate_damping_beta;
    logic [7:0] beta_lp1;
    logic [7:0] beta_lp2;
    logic [5:0] ref_interval;
    logic [ch_w-1:0] sel;
    logic [17:0] alp_filt;
    logic [17:0] alp_lta;
    logic alp_raw_det;
    logic alp_sample;
    logic [31:0] sec_cnt;
    logic [5:0] sec_elapsed;
    logic refresh_due;
    logic [7:0] sleep_done;
    logic sleep_wake;
    logic touch_any;
  } core_state_t;

  core_state_t st_reg, st_next;
  logic [15:0] count_mem [ch_max];
  logic [15:0] ref_mem [ch_max];
  logic [ch_max-1:0] touch_reg;
  logic [ch_max-1:0] touch_next;
  logic [ch_max-1:0] tp_seed_all;
  logic tp_wr;
  logic [ch_w-1:0] tp_idx;
  logic [15:0] tp_clamped;
  logic [17:0] alp_sum;
  logic [17:0] alp_clamped;
  logic [17:0] alp_filt_new;
  logic [17:0] alp_dev;
  logic wr_en;
  logic rd_en;
  logic trackpad_refseed_request_pulse;
  logic alternate_refseed_request_pulse;
  logic in_lp;
  alp_debounce_if dbif();

  assign in_lp = (power_mode == 2'(mode_lp1)) || (power_mode == 2'(mode_lp2));
  assign wr_en = psel && penable && pwrite && st_reg.ready;
  assign rd_en = psel && !penable && !pwrite;
  assign trackpad_refseed_request_pulse = wr_en && (paddr == off_ctrl) && pwdata[8];
  assign alternate_refseed_request_pulse = wr_en && (paddr == off_ctrl) && pwdata[9];

  assign tp_idx = ch_w'((32'(tp_row) * 32'(st_reg.receive_column_total)) + 32'(tp_col));
  // Trackpad frame ignored in low power
  assign tp_wr = tp_valid && !in_lp && (tp_row < st_reg.transmit_row_total)
    && (tp_col < st_reg.receive_column_total);
  assign tp_clamped = (tp_raw > st_reg.max_count) ? st_reg.max_count : tp_raw;
  assign alp_sum = (|st_reg.rx_en[3:0] ? 18'(engine_a_raw) : 18'h0_0000)
    + (|st_reg.rx_en[7:4] ? 18'(engine_b_raw) : 18'h0_0000);
  assign alp_clamped = (alp_sum > 18'(st_reg.max_count)) ? 18'(st_reg.max_count) : alp_sum;
  assign alp_filt_new = st_reg.count_filter_en ? damp_step(st_reg.alp_filt, alp_clamped,
    st_reg.alternate_damping_beta) : alp_clamped;
  assign alp_dev = (alp_filt_new > st_reg.alp_lta) ? alp_filt_new - st_reg.alp_lta
    : st_reg.alp_lta - alp_filt_new;
  // Refresh when due in low power with manual clear, or by host reseed
  assign tp_seed_all = {ch_max{trackpad_refseed_request_pulse || (st_reg.refresh_due && in_lp && !st_reg.manual)}};

  // Count and reference storage
  always_ff @(posedge pclk)
  begin
    if (tp_wr)
      count_mem[tp_idx] <= tp_clamped;
    for (int i = 0; i < ch_max; i++)
    begin
      if (tp_seed_all[i])
        ref_mem[i] <= count_mem[i];
    end
  end

  always_comb
  begin
    touch_next = touch_reg;
    for (int i = 0; i < ch_max; i++)
    begin
      if (!touch_reg[i] && (24'(count_mem[i]) > ref_thr(ref_mem[i], st_reg.set_mult)))
        touch_next[i] = 1'b1;
      else if (touch_reg[i] && (24'(count_mem[i]) < ref_thr(ref_mem[i], st_reg.clr_mult)))
        touch_next[i] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      touch_reg <= '0;
    else
      touch_reg <= touch_next;
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.ready = psel && !st_reg.ready;
    st_next.err = 1'b0;
    st_next.alp_sample = 1'b0;
    st_next.refresh_due = 1'b0;
    st_next.touch_any = |touch_reg;
    if (wr_en)
    begin
      unique case (paddr)
        off_ctrl:
        begin
          st_next.manual = pwdata[0];
          st_next.count_filter_en = pwdata[1];
          st_next.sense_self = pwdata[2];
          st_next.ref_interval = (pwdata[21:16] > 6'(ref_interval_max_s)) ? 6'(ref_interval_max_s)
            : pwdata[21:16];
          st_next.receive_column_total = pwdata[27:24];
          st_next.transmit_row_total = pwdata[31:28];
        end
        off_alp_cfg:
        begin
          st_next.rx_en = pwdata[7:0];
          st_next.tx_en = pwdata[15:8];
          st_next.sleep_sensing_cycle_count = pwdata[23:16];
        end
        off_thr:
        begin
          st_next.set_mult = pwdata[7:0];
          st_next.clr_mult = pwdata[15:8];
          st_next.alternate_delta_limit = pwdata[31:16];
        end
        off_max:
        begin
          st_next.max_count = pwdata[15:0];
          st_next.assert_cnt = pwdata[23:16];
          st_next.release_cnt = pwdata[31:24];
        end
        off_beta:
        begin
          st_next.alternate_damping_beta = pwdata[7:0];
          st_next.beta_lp1 = pwdata[15:8];
          st_next.beta_lp2 = pwdata[23:16];
        end
        off_sel: st_next.sel = pwdata[ch_w-1:0];
        default: st_next.err = 1'b0;
      endcase
    end
    if (rd_en)
    begin
      unique case (paddr)
        off_ctrl: st_next.rdata = {st_reg.transmit_row_total, st_reg.receive_column_total, 2'b00,
          st_reg.ref_interval, 13'h0000, st_reg.sense_self, st_reg.count_filter_en, st_reg.manual};
        off_alp_cfg: st_next.rdata = {8'h00, st_reg.sleep_sensing_cycle_count, st_reg.tx_en, st_reg.rx_en};
        off_thr: st_next.rdata = {st_reg.alternate_delta_limit, st_reg.clr_mult, st_reg.set_mult};
        off_max: st_next.rdata = {st_reg.release_cnt, st_reg.assert_cnt, st_reg.max_count};
        off_beta: st_next.rdata = {8'h00, st_reg.beta_lp2, st_reg.beta_lp1, st_reg.alternate_damping_beta};
        off_status: st_next.rdata = {24'h00_0000, st_reg.sleep_done[3:0], st_reg.sleep_wake,
          st_reg.touch_any, st_reg.alp_raw_det, dbif.flag};
        off_alp_cnt: st_next.rdata = {14'h0000, st_reg.alp_filt};
        off_alp_lta: st_next.rdata = {14'h0000, st_reg.alp_lta};
        off_sel: st_next.rdata = 32'(st_reg.sel);
        off_ch: st_next.rdata = {16'(count_mem[st_reg.sel] - ref_mem[st_reg.sel]), count_mem[st_reg.sel]};
        off_touch: st_next.rdata = 32'(touch_reg);
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    if (psel && !penable)
      st_next.err = !(paddr <= off_touch) || (paddr[1:0] != 2'b00);
    if (st_reg.sec_cnt >= sec_cycles - 1)
    begin
      st_next.sec_cnt = 32'h0000_0000;
      if (st_reg.sec_elapsed + 6'h01 >= st_reg.ref_interval)
      begin
        st_next.sec_elapsed = 6'h00;
        st_next.refresh_due = 1'b1;
      end
      else
        st_next.sec_elapsed = st_reg.sec_elapsed + 6'h01;
    end
    else
      st_next.sec_cnt = st_reg.sec_cnt + 32'h0000_0001;
    if (alp_valid && in_lp)
    begin
      st_next.alp_filt = alp_filt_new;
      if (!st_reg.alp_raw_det)
        st_next.alp_lta = damp_step(st_reg.alp_lta, st_reg.alp_filt,
          (power_mode == 2'(mode_lp1)) ? st_reg.beta_lp1 : st_reg.beta_lp2);
      st_next.alp_raw_det = alp_dev > 18'(st_reg.alternate_delta_limit);
      st_next.alp_sample = 1'b1;
      if (core_asleep)
      begin
        st_next.sleep_wake = st_reg.sleep_wake || (st_reg.sleep_done + 8'h01 >= st_reg.sleep_sensing_cycle_count);
        st_next.sleep_done = st_next.sleep_wake ? 8'h00 : st_reg.sleep_done + 8'h01;
      end
    end
    if (!core_asleep)
      st_next.sleep_wake = 1'b0;
    if (alternate_refseed_request_pulse)
      st_next.alp_lta = st_reg.alp_filt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
      st_reg.max_count <= max_count_rst;
      st_reg.alternate_damping_beta <= beta_rst;
      st_reg.beta_lp1 <= beta_rst;
      st_reg.beta_lp2 <= beta_rst;
      st_reg.ref_interval <= ref_interval_rst;
      st_reg.sleep_sensing_cycle_count <= sleep_cycles_rst;
      st_reg.count_filter_en <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign dbif.raw = st_reg.alp_raw_det;
  assign dbif.set_cnt = st_reg.assert_cnt;
  assign dbif.clr_cnt = st_reg.release_cnt;

  alp_debounce u_db (
    .pclk(pclk),
    .presetn(presetn),
    .sample(st_reg.alp_sample),
    .db(dbif.filt)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alternate_detect_flag <= 1'b0;
      alp_sensing_active <= 1'b0;
    end
    else
    begin
      alternate_detect_flag <= dbif.flag;
      alp_sensing_active <= in_lp;
    end
  end
  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.err;
  assign any_touch = st_reg.touch_any;
  assign sleep_cycle_wake = st_reg.sleep_wake;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  // Stored count never above max
  chk_count_clamp: assert property (@(posedge pclk) disable iff (!presetn)
    tp_wr |=> count_mem[$past(tp_idx)] <= $past(st_reg.max_count)) else $error("count above max");
  chk_alternate_refseed_request: assert property (@(posedge pclk) disable iff (!presetn)
    alternate_refseed_request_pulse |=> st_reg.alp_lta == $past(st_reg.alp_filt)) else $error("alternate reseed missed");
  chk_trackpad_refseed_request: assert property (@(posedge pclk) disable iff (!presetn)
    trackpad_refseed_request_pulse |=> ref_mem[$past(st_reg.sel)] == $past(count_mem[st_reg.sel]))
    else $error("trackpad reseed missed");
  // No trackpad capture in low power
  chk_lp_no_tp: assert property (@(posedge pclk) disable iff (!presetn)
    (tp_valid && in_lp) |-> !tp_wr) else $error("trackpad written in low power");
  chk_touch_set: assert property (@(posedge pclk) disable iff (!presetn)
    (!touch_reg[st_reg.sel] && 24'(count_mem[st_reg.sel]) > ref_thr(ref_mem[st_reg.sel], st_reg.set_mult)) |=>
    touch_reg[$past(st_reg.sel)]) else $error("touch not set");
  chk_touch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (touch_reg[st_reg.sel] && 24'(count_mem[st_reg.sel]) >= ref_thr(ref_mem[st_reg.sel], st_reg.clr_mult)) |=>
    touch_reg[$past(st_reg.sel)]) else $error("touch cleared early");
  chk_interval_max: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.ref_interval <= 6'(ref_interval_max_s)) else $error("interval above limit");
  // APB answers one to two cycles after setup
  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> ##[0:1] pready) else $error("no ready");
  cov_touch: cover property (@(posedge pclk) disable iff (!presetn) $rose(any_touch));
  cov_alp_det: cover property (@(posedge pclk) disable iff (!presetn) $rose(alternate_detect_flag));
  cov_refresh: cover property (@(posedge pclk) disable iff (!presetn) st_reg.refresh_due && in_lp);
endmodule

// >>> testbench/frontend_model.sv
// Front-end model: delivers trackpad and alternate-channel counts.
// Assumes its tasks are called by the bench from clocked code.
`timescale 1ns/1ps
module frontend_model (
  input wire logic pclk,
  output logic tp_valid,
  output logic [3:0] tp_row,
  output logic [3:0] tp_col,
  output logic [15:0] tp_raw,
  output logic alp_valid,
  output logic [15:0] engine_a_raw,
  output logic [15:0] engine_b_raw
);
  initial
  begin
    tp_valid = 1'b0;
    tp_row = 4'h0;
    tp_col = 4'h0;
    tp_raw = 16'h0000;
    alp_valid = 1'b0;
    engine_a_raw = 16'h0000;
    engine_b_raw = 16'h0000;
  end
  task automatic send_tp(input logic [3:0] r, input logic [3:0] c, input logic [15:0] v);
    @(posedge pclk);
    tp_valid <= 1'b1;
    tp_row <= r;
    tp_col <= c;
    tp_raw <= v;
    @(posedge pclk);
    tp_valid <= 1'b0;
    tp_row <= ~r;
    tp_col <= ~c;
    tp_raw <= ~v;
  endtask
  task automatic send_alp(input logic [15:0] a, input logic [15:0] b);
    @(posedge pclk);
    alp_valid <= 1'b1;
    engine_a_raw <= a;
    engine_b_raw <= b;
    @(posedge pclk);
    alp_valid <= 1'b0;
    engine_a_raw <= ~a;
    engine_b_raw <= ~b;
  endtask
endmodule

// >>> testbench/testbench.sv
// Testbench for tp_proc: APB register access and front-end driven scenarios.
// Assumes frontend_model as count source; one second shortened to 20 cycles.
`timescale 1ns/1ps
module testbench;
  import tp_proc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, core_asleep = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, tp_valid, alp_valid, flag, any_touch, alp_act, wake, e;
  logic [1:0] power_mode = 2'h0;
  logic [3:0] tp_row, tp_col;
  logic [15:0] tp_raw, ea, eb;
  int n_fail = 0, checked = 0, cyc = 0;
  always #4 pclk = ~pclk;
  frontend_model fe (.pclk(pclk), .tp_valid(tp_valid), .tp_row(tp_row), .tp_col(tp_col), .tp_raw(tp_raw),
    .alp_valid(alp_valid), .engine_a_raw(ea), .engine_b_raw(eb));
  tp_proc #(.sec_cycles(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_mode(power_mode), .core_asleep(core_asleep), .tp_valid(tp_valid), .tp_row(tp_row),
    .tp_col(tp_col), .tp_raw(tp_raw), .alp_valid(alp_valid), .engine_a_raw(ea), .engine_b_raw(eb),
    .alternate_detect_flag(flag), .any_touch(any_touch), .alp_sensing_active(alp_act),
    .sleep_cycle_wake(wake));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp, what);
  endtask
  // Signal codes: 0 sensing active, 1 detect flag, 2 any touch, 3 sleep wake
  task automatic wait_chk(input int sig, input logic exp, input string what);
    logic got;
    repeat (3) @(posedge pclk);
    case (sig)
      0: got = alp_act;
      1: got = flag;
      2: got = any_touch;
      default: got = wake;
    endcase
    chk({31'h0000_0000, got}, {31'h0000_0000, exp}, what);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd_chk(off_ctrl, 32'h000a_0002, "ctrl reset");
    rd_chk(off_max, 32'h0000_ffff, "max reset");
    rd_chk(off_beta, 32'h0008_0808, "beta reset");
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk(q, 32'h0000_0000, "unmapped read");
    chk({31'h0000_0000, e}, 32'h0000_0001, "unmapped error");
    apb(1'b1, off_ctrl, 32'h003f_0006);
    rd_chk(off_ctrl, 32'h003c_0006, "interval clip");
    apb(1'b1, off_alp_cfg, 32'h0002_0fff);
    rd_chk(off_alp_cfg, 32'h0002_0fff, "alt config");
  endtask
  task automatic t_alp;
    apb(1'b1, off_ctrl, 32'h000a_0002);
    apb(1'b1, off_beta, 32'h0008_08ff);
    power_mode <= 2'h2;
    wait_chk(0, 1'b1, "lp sensing");
    fe.send_alp(16'h012c, 16'h0190);
    rd_chk(off_alp_cnt, 32'h0000_02b6, "filtered sum");
    apb(1'b1, off_ctrl, 32'h000a_0000);
    fe.send_alp(16'h012c, 16'h0190);
    rd_chk(off_alp_cnt, 32'h0000_02bc, "raw sum");
    wait_chk(1, 1'b1, "zero assert count");
    apb(1'b1, off_ctrl, 32'h000a_0200);
    rd_chk(off_alp_lta, 32'h0000_02bc, "alt reseed");
    fe.send_alp(16'h015e, 16'h015e);
    wait_chk(1, 1'b0, "zero release count");
    apb(1'b1, off_thr, 32'h0032_0000);
    apb(1'b1, off_max, 32'h0202_ffff);
    fe.send_alp(16'h0177, 16'h0177);
    apb(1'b0, off_status, 32'h0000_0000);
    chk({31'h0, q[1]}, 32'h0, "limit boundary");
    fe.send_alp(16'h017c, 16'h017c);
    wait_chk(1, 1'b0, "assert early");
    repeat (3) fe.send_alp(16'h017c, 16'h017c);
    wait_chk(1, 1'b1, "assert late");
    rd_chk(off_alp_lta, 32'h0000_02bd, "average frozen");
    fe.send_alp(16'h015e, 16'h015e);
    wait_chk(1, 1'b1, "release early");
    repeat (3) fe.send_alp(16'h015e, 16'h015e);
    wait_chk(1, 1'b0, "release late");
    core_asleep <= 1'b1;
    repeat (3) fe.send_alp(16'h015e, 16'h015e);
    wait_chk(3, 1'b1, "sleep wake");
    core_asleep <= 1'b0;
    wait_chk(3, 1'b0, "awake clear");
    power_mode <= 2'h0;
    wait_chk(0, 1'b0, "active mode");
  endtask
  task automatic t_tp;
    apb(1'b1, off_ctrl, 32'h340a_0003);
    apb(1'b1, off_thr, 32'h0032_0810);
    apb(1'b1, off_sel, 32'h0000_0006);
    fe.send_tp(4'h1, 4'h2, 16'd1000);
    apb(1'b1, off_ctrl, 32'h340a_0103);
    fe.send_tp(4'h1, 4'h2, 16'd1100);
    rd_chk(off_ch, 32'h0064_044c, "channel six");
    fe.send_tp(4'h1, 4'h2, 16'd900);
    rd_chk(off_ch, 32'hff9c_0384, "negative delta");
    fe.send_tp(4'h1, 4'h2, 16'd1125);
    rd_chk(off_touch, 32'h0000_0000, "set boundary");
    fe.send_tp(4'h1, 4'h2, 16'd1126);
    rd_chk(off_touch, 32'h0000_0040, "touch set");
    wait_chk(2, 1'b1, "any touch");
    fe.send_tp(4'h1, 4'h2, 16'd1062);
    rd_chk(off_touch, 32'h0000_0040, "hysteresis");
    fe.send_tp(4'h1, 4'h2, 16'd1061);
    rd_chk(off_touch, 32'h0000_0000, "touch clear");
    wait_chk(2, 1'b0, "release");
    apb(1'b1, off_max, 32'h0202_07d0);
    fe.send_tp(4'h1, 4'h2, 16'd3000);
    rd_chk(off_ch, 32'h03e8_07d0, "max clamp");
    apb(1'b1, off_ctrl, 32'h3401_0002);
    fe.send_tp(4'h1, 4'h2, 16'd1000);
    fe.send_tp(4'h1, 4'h2, 16'd1100);
    repeat (60) @(posedge pclk);
    rd_chk(off_ch, 32'h0064_044c, "no active refresh");
    power_mode <= 2'h3;
    repeat (60) @(posedge pclk);
    rd_chk(off_ch, 32'h0000_044c, "lp refresh");
  endtask
  // ----------------------------------------
  // Main sequence and timeout
  // ----------------------------------------
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_alp();
    t_tp();
    end_of_test();
  end
endmodule
